/* File: logic/ilc_cfg.svh */
// Purpose: constants for the instruction loop cache
// Assumes: one 40 MHz instruction clock, synchronous active-high reset
// Notes: widths, reset values and timing counts live here; types live in ilc_pkg
//
// Behaviour
// - Store holds sixteen entries of one 24-bit instruction each.
// - Every memory fetch is also written at entry given by address low four bits.
// - Next instruction is fetched while the current one executes.
// - Data transfer on program bus loads instruction register from the store.
// - Invalid store entry clears instruction register; one extra cycle fetches it.
// - Store is the source only when a data access collides with fetch.
// - Monitor keeps counts of valid entries ahead of and behind execution.
// - Validity covers only contiguous addresses, at most sixteen words.
// - Jump outside the held range invalidates every entry.
// - After invalidation valid count grows with each sequential fetch up to sixteen.
// - Full store overwrites the oldest entry, index wrapping modulo sixteen.
// - Jumps and loop-backs inside the held region keep entries valid.
// - Loop fitting in the store misses only on its first pass.
// - Cached loop takes instruction from store while both data buses move operands.
// - Caching needs no software setup, maintenance or special instructions.
`ifndef ILC_CFG_SVH
`define ILC_CFG_SVH

`define ILC_WORD_W 24
`define ILC_DEPTH 16
`define ILC_IDX_W 4
`define ILC_ADDR_W 14
`define ILC_CNT_W 5
`define ILC_CNT_FULL 5'h10
`define ILC_CNT_RESET 5'h00
`define ILC_IR_RESET 24'h000000
`define ILC_ADDR_RESET 14'h0000
`define ILC_MISS_CYCLES 1

`endif

/* File: logic/ilc_pkg.sv */
// Purpose: types shared by the instruction loop cache files
// Assumes: ilc_cfg.svh supplies the widths
// Notes: the whole state of the top module is one packed struct
`include "ilc_cfg.svh"

package ilc_pkg;

    typedef logic [`ILC_ADDR_W-1:0] ilc_addr_t;
    typedef logic [`ILC_WORD_W-1:0] ilc_word_t;
    typedef logic [`ILC_IDX_W-1:0] ilc_idx_t;
    typedef logic [`ILC_CNT_W-1:0] ilc_cnt_t;

    typedef enum logic [0:0] {ILC_RUN, ILC_MISS} ilc_state_t;

    typedef struct packed {
        ilc_state_t state;
        ilc_word_t ir;
        logic ir_valid;
        logic from_cache;
        logic stall;
        ilc_addr_t top;
        ilc_cnt_t cnt;
        ilc_addr_t exec;
        ilc_cnt_t ahead;
        ilc_cnt_t behind;
    } ilc_regs_t;

endpackage

/* File: logic/ilc_store.sv */
// Purpose: sixteen-word instruction store with one write and one read port
// Assumes: write on the clock edge, read is combinational
// Notes: no reset on the array; validity is tracked outside by the monitor
`timescale 1ns/1ps
`include "ilc_cfg.svh"

module ilc_store (
    input wire logic sys_clk, // instruction clock
    input wire logic we, // write strobe
    input wire ilc_pkg::ilc_idx_t waddr, // write index
    input wire ilc_pkg::ilc_word_t wdata, // instruction to store
    input wire ilc_pkg::ilc_idx_t raddr, // read index
    output ilc_pkg::ilc_word_t rdata // stored instruction
);
    import ilc_pkg::*;

    ilc_word_t mem [`ILC_DEPTH];

    // contents need no reset, so the array stays plain storage
    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule

/* File: logic/ilc_top.sv */
// Purpose: instruction loop cache with contiguity monitor for a program sequencer
// Assumes: sequencer presents the next fetch address each cycle and holds it while stall is high
// Notes: no software-visible registers; the cache works transparently
`timescale 1ns/1ps
`include "ilc_cfg.svh"

module ilc_top (
    input wire logic sys_clk, // instruction clock, 40 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic fetch_req, // sequencer wants an instruction this cycle
    input wire ilc_pkg::ilc_addr_t fetch_addr, // program address of that instruction
    input wire logic pm_data_xfer, // program bus carries a data transfer this cycle
    input wire ilc_pkg::ilc_word_t program_memory_data_bus, // instruction from program memory
    output ilc_pkg::ilc_word_t instr_word, // instruction register
    output logic instr_valid, // instruction register loaded with a good word this cycle
    output logic instr_from_cache, // that word came from the store
    output logic stall, // miss cycle: hold the fetch address
    output ilc_pkg::ilc_cnt_t ahead_count, // valid entries ahead of execution
    output ilc_pkg::ilc_cnt_t behind_count // valid entries behind execution
);
    import ilc_pkg::*;

    ilc_regs_t r;
    ilc_regs_t next_r;
    ilc_word_t cache_rdata;
    logic st_we;
    logic hit;
    logic run_req;

    // address lies in the contiguous window ending at top, cnt words long
    function automatic logic in_region(ilc_addr_t a, ilc_addr_t top, ilc_cnt_t cnt);
        ilc_addr_t diff;
        diff = top - a;
        return (cnt != `ILC_CNT_RESET) && (diff < ilc_addr_t'(cnt));
    endfunction

    // count after fetching address a from memory
    function automatic ilc_cnt_t grown_cnt(ilc_addr_t a, ilc_addr_t top, ilc_cnt_t cnt);
        ilc_cnt_t res;
        res = cnt;
        if (cnt != `ILC_CNT_RESET && a == top + ilc_addr_t'(1))
        begin
            res = (cnt == `ILC_CNT_FULL) ? cnt : cnt + ilc_cnt_t'(1);
        end
        else if (!in_region(a, top, cnt))
        begin
            res = ilc_cnt_t'(1); // out-of-range target restarts the window
        end
        return res;
    endfunction

    // new top of window after fetching address a from memory
    function automatic ilc_addr_t grown_top(ilc_addr_t a, ilc_addr_t top, ilc_cnt_t cnt);
        return in_region(a, top, cnt) ? top : a;
    endfunction

    ilc_store u_store (
        .sys_clk(sys_clk),
        .we(st_we),
        .waddr(fetch_addr[`ILC_IDX_W-1:0]),
        .wdata(program_memory_data_bus),
        .raddr(fetch_addr[`ILC_IDX_W-1:0]),
        .rdata(cache_rdata)
    );

    assign hit = in_region(fetch_addr, r.top, r.cnt);
    assign run_req = (r.state == ILC_RUN) && fetch_req;

    // source selection, miss handling and monitor update
    always_comb
    begin
        next_r = r;
        st_we = 1'b0;
        next_r.ir_valid = 1'b0;
        next_r.from_cache = 1'b0;
        case (r.state)
            ILC_RUN:
            begin
                if (fetch_req)
                begin
                    next_r.exec = fetch_addr;
                    if (pm_data_xfer)
                    begin
                        if (hit)
                        begin
                            next_r.ir = cache_rdata;
                            next_r.ir_valid = 1'b1;
                            next_r.from_cache = 1'b1;
                        end
                        else
                        begin
                            next_r.ir = `ILC_IR_RESET;
                            next_r.stall = 1'b1;
                            next_r.state = ILC_MISS;
                        end
                    end
                    else
                    begin
                        // prefetch path: memory feeds the register and the store together
                        next_r.ir = program_memory_data_bus;
                        next_r.ir_valid = 1'b1;
                        st_we = 1'b1;
                        next_r.cnt = grown_cnt(fetch_addr, r.top, r.cnt);
                        next_r.top = grown_top(fetch_addr, r.top, r.cnt);
                    end
                end
            end
            ILC_MISS:
            begin
                // extra cycle: program bus is free again, fetch the missed word
                next_r.ir = program_memory_data_bus;
                next_r.ir_valid = 1'b1;
                next_r.stall = 1'b0;
                st_we = 1'b1;
                next_r.cnt = grown_cnt(r.exec, r.top, r.cnt);
                next_r.top = grown_top(r.exec, r.top, r.cnt);
                next_r.state = ILC_RUN;
            end
            default:
            begin
                next_r.state = ILC_RUN;
            end
        endcase
        // counts are measured from the executing address, so a branch re-centres them
        if (in_region(next_r.exec, next_r.top, next_r.cnt))
        begin
            next_r.ahead = ilc_cnt_t'(next_r.top - next_r.exec);
            next_r.behind = next_r.cnt - next_r.ahead - ilc_cnt_t'(1);
        end
        else
        begin
            next_r.ahead = `ILC_CNT_RESET;
            next_r.behind = `ILC_CNT_RESET;
        end
    end

    // all state registered here; reset empties the window
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            r.state <= ILC_RUN;
            r.ir <= `ILC_IR_RESET;
            r.ir_valid <= 1'b0;
            r.from_cache <= 1'b0;
            r.stall <= 1'b0;
            r.top <= `ILC_ADDR_RESET;
            r.cnt <= `ILC_CNT_RESET;
            r.exec <= `ILC_ADDR_RESET;
            r.ahead <= `ILC_CNT_RESET;
            r.behind <= `ILC_CNT_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs straight from the state flops; no config inputs exist
    assign instr_word = r.ir;
    assign instr_valid = r.ir_valid;
    assign instr_from_cache = r.from_cache;
    assign stall = r.stall;
    assign ahead_count = r.ahead;
    assign behind_count = r.behind;

    sequence s_miss_enter;
        !instr_valid && stall && instr_word == `ILC_IR_RESET;
    endsequence

    sequence s_miss_leave;
        !stall && instr_valid && !instr_from_cache;
    endsequence

    property p_store_write;
        @(posedge sys_clk) disable iff (srst)
        run_req && !pm_data_xfer |-> st_we ##1 instr_word == $past(program_memory_data_bus);
    endproperty
    a_store_write: assert property (p_store_write) else $error("memory fetch not stored");

    property p_cache_src;
        @(posedge sys_clk) disable iff (srst)
        run_req && pm_data_xfer && hit |=> instr_from_cache && instr_valid && instr_word == $past(cache_rdata);
    endproperty
    a_cache_src: assert property (p_cache_src) else $error("hit not served from store");

    property p_miss;
        @(posedge sys_clk) disable iff (srst)
        run_req && pm_data_xfer && !hit |=> s_miss_enter ##1 s_miss_leave;
    endproperty
    a_miss: assert property (p_miss) else $error("miss sequence wrong");

    property p_mem_src;
        @(posedge sys_clk) disable iff (srst)
        run_req && !pm_data_xfer |=> !instr_from_cache && !stall;
    endproperty
    a_mem_src: assert property (p_mem_src) else $error("store used without collision");

    property p_invalidate;
        @(posedge sys_clk) disable iff (srst)
        run_req && !pm_data_xfer && !hit && r.cnt != 0 && fetch_addr != r.top + ilc_addr_t'(1)
            |=> r.cnt == 1;
    endproperty
    a_invalidate: assert property (p_invalidate) else $error("jump out did not invalidate");

    property p_grow;
        @(posedge sys_clk) disable iff (srst)
        run_req && !pm_data_xfer && r.cnt != 0 && r.cnt < 16 && fetch_addr == r.top + ilc_addr_t'(1)
            |=> r.cnt == $past(r.cnt) + 1;
    endproperty
    a_grow: assert property (p_grow) else $error("valid count did not grow");

    property p_keep;
        @(posedge sys_clk) disable iff (srst)
        run_req && hit |=> r.cnt == $past(r.cnt) && r.top == $past(r.top);
    endproperty
    a_keep: assert property (p_keep) else $error("in-region branch lost entries");

    property p_counts;
        @(posedge sys_clk) disable iff (srst)
        (r.cnt <= 16) and (instr_valid |-> ahead_count + behind_count + 1 == r.cnt);
    endproperty
    a_counts: assert property (p_counts) else $error("monitor counts inconsistent");

    property p_reset;
        @(posedge sys_clk)
        srst |=> ahead_count == 0 && behind_count == 0 && r.cnt == 0 && !stall;
    endproperty
    a_reset: assert property (p_reset) else $error("reset left entries valid");
endmodule

/* File: bench/ilc_pmem.sv */
// Purpose: program memory model on the far side of the instruction loop cache
// Assumes: word at an address is a fixed pattern the bench can recompute
// Notes: outside fetch and miss cycles the bus shows the inverse of its last value
`timescale 1ns/1ps

module ilc_pmem (
    input wire logic sys_clk, // instruction clock
    input wire logic fetch_req, // fetch request from the sequencer
    input wire ilc_pkg::ilc_addr_t fetch_addr, // program address
    input wire logic pm_data_xfer, // bus taken by a data transfer
    input wire logic stall, // miss cycle in progress
    output ilc_pkg::ilc_word_t program_memory_data_bus // instruction word
);
    import ilc_pkg::*;
    ilc_word_t last;
    // drive only when the word is really fetched, so a stale value never passes as good
    always_comb
    begin
        if ((fetch_req && !pm_data_xfer) || stall)
            program_memory_data_bus = {10'h2C5, fetch_addr};
        else
            program_memory_data_bus = ~last;
    end
    // remember the last driven value for the released-bus pattern
    always_ff @(posedge sys_clk)
        last <= program_memory_data_bus;
endmodule

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the instruction loop cache
// Assumes: inputs change at the falling edge; outputs checked one falling edge later
// Notes: expected words follow the pattern of the program memory model
`timescale 1ns/1ps

module testbench;
    import ilc_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic fetch_req = 1'b0;
    ilc_addr_t fetch_addr = 14'h0000;
    logic pm_data_xfer = 1'b0;
    ilc_word_t bus, instr_word;
    logic instr_valid, instr_from_cache, stall;
    ilc_cnt_t ahead_count, behind_count;
    int n_fail = 0;
    int samples_checked = 0;

    ilc_top dut (.sys_clk(sys_clk), .srst(srst), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .pm_data_xfer(pm_data_xfer), .program_memory_data_bus(bus), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_from_cache(instr_from_cache), .stall(stall),
        .ahead_count(ahead_count), .behind_count(behind_count));
    ilc_pmem pmem (.sys_clk(sys_clk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .pm_data_xfer(pm_data_xfer), .stall(stall), .program_memory_data_bus(bus));

    // 40 MHz instruction clock
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one request; a miss is checked over its stall cycle and the reload cycle
    task automatic step(input ilc_addr_t a, input logic x, input logic miss, input ilc_cnt_t ah, bh);
        fetch_req = 1'b1;
        fetch_addr = a;
        pm_data_xfer = x;
        @(negedge sys_clk);
        if (miss)
        begin
            chk({23'h0, stall}, 24'h000001);
            chk({23'h0, instr_valid}, 24'h000000);
            chk(instr_word, 24'h000000);
            @(negedge sys_clk);
            chk({23'h0, stall}, 24'h000000);
        end
        chk({23'h0, instr_valid}, 24'h000001);
        chk(instr_word, {10'h2C5, a});
        chk({23'h0, instr_from_cache}, {23'h0, x && !miss});
        chk({19'h0, ahead_count}, {19'h0, ah});
        chk({19'h0, behind_count}, {19'h0, bh});
    endtask

    // sequential fill past sixteen words, then hits and an overwritten entry
    task automatic t_fill();
        for (int i = 0; i < 20; i++)
            step(14'h0100 + 14'(i), 1'b0, 1'b0, 5'h00, (i < 15) ? 5'(i) : 5'h0F);
        step(14'h010A, 1'b1, 1'b0, 5'h09, 5'h06);
        step(14'h0104, 1'b1, 1'b0, 5'h0F, 5'h00);
        step(14'h0103, 1'b1, 1'b1, 5'h00, 5'h00);
        $display("fill test done");
    endtask

    // four-word loop: one miss on the first pass, hits on later passes
    task automatic t_loop();
        step(14'h0200, 1'b0, 1'b0, 5'h00, 5'h00);
        step(14'h0201, 1'b0, 1'b0, 5'h00, 5'h01);
        step(14'h0202, 1'b0, 1'b0, 5'h00, 5'h02);
        step(14'h0203, 1'b1, 1'b1, 5'h00, 5'h03);
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 4; i++)
                step(14'h0200 + 14'(i), 1'b1, 1'b0, 5'(3 - i), 5'(i));
        fetch_req = 1'b0;
        pm_data_xfer = 1'b0;
        @(negedge sys_clk);
        chk({23'h0, instr_valid}, 24'h000000);
        $display("loop test done");
    endtask

    // reset in mid-run empties the window, so a former hit becomes a miss
    task automatic t_reset();
        srst = 1'b1;
        @(negedge sys_clk);
        chk({19'h0, ahead_count}, 24'h000000);
        chk({19'h0, behind_count}, 24'h000000);
        chk({23'h0, instr_valid}, 24'h000000);
        srst = 1'b0;
        @(negedge sys_clk);
        step(14'h0201, 1'b1, 1'b1, 5'h00, 5'h00);
        // a request dropped during the stall cycle is ignored; the held address is reloaded
        fetch_addr = 14'h0300;
        pm_data_xfer = 1'b1;
        @(negedge sys_clk);
        chk({23'h0, stall}, 24'h000001);
        fetch_req = 1'b0;
        pm_data_xfer = 1'b0;
        @(negedge sys_clk);
        chk({23'h0, instr_valid}, 24'h000001);
        chk(instr_word, {10'h2C5, 14'h0300});
        chk({19'h0, behind_count}, 24'h000000);
        @(negedge sys_clk);
        chk({23'h0, instr_valid}, 24'h000000);
        $display("reset test done");
    endtask

    // watchdog: the tests take well under 200 cycles
    initial
    begin
        #20us;
        n_fail++;
        final_report();
    end

    initial
    begin
        repeat (4) @(negedge sys_clk);
        srst = 1'b0;
        @(negedge sys_clk);
        t_fill();
        t_loop();
        t_reset();
        final_report();
    end
endmodule
